// file: design/dma_pkg.sv
`default_nettype none
package dma_pkg;
  // channel count and counter widths of the eight-channel build
  localparam int          NCH         = 8;
  localparam int          CNT_W       = 16;
  localparam int          BLK_W       = 16;
  localparam int          BSZ_W       = 10;

  // global register byte addresses
  localparam logic [11:0] A_IRQ_STAT  = 12'h100;
  localparam logic [11:0] A_IRQ_CLR   = 12'h104;
  localparam logic [11:0] A_IRQ_EN    = 12'h108;
  localparam logic [11:0] A_UPMON     = 12'h10C;
  localparam logic [11:0] A_STOP      = 12'h110;

  // per-channel word index inside a 32-byte channel window
  localparam logic [2:0]  R_SRC       = 3'h0;
  localparam logic [2:0]  R_DST       = 3'h1;
  localparam logic [2:0]  R_CNT       = 3'h2;
  localparam logic [2:0]  R_BLK       = 3'h3;
  localparam logic [2:0]  R_MODE      = 3'h4;
  localparam logic [2:0]  R_CTRL      = 3'h5;
  localparam logic [2:0]  R_SWREQ     = 3'h6;
  localparam logic [2:0]  R_CHST      = 3'h7;

  // mode register field positions, and the block size field of the count register
  localparam int          MODE_LSB    = 0;
  localparam int          SIZE_LSB    = 2;
  localparam int          FREE_BIT    = 4;
  localparam int          RSIDE_BIT   = 5;
  localparam int          SINC_BIT    = 6;
  localparam int          DINC_BIT    = 7;
  localparam int          SAREA_LSB   = 8;
  localparam int          DAREA_LSB   = 16;
  localparam int          TRIG_BIT    = 24;
  localparam int          BSZ_LSB     = 16;

  // largest repeat area: 2**27 bytes is 128 MB
  localparam logic [4:0]  AREA_MAX    = 5'h1B;

  // values after reset
  localparam logic [31:0] MODE_RST    = 32'h0000_0000;
  localparam logic        STOP_RST    = 1'b0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_REPEAT = 2'h1,
    MODE_BLOCK  = 2'h2
  } xfer_mode_e;

  typedef enum {ST_IDLE, ST_MOVE} eng_state_e;
  typedef enum {PS_IDLE, PS_RD, PS_WR} port_state_e;
endpackage
`default_nettype wire

// file: design/xfer_if.sv
`default_nettype none
interface xfer_if;
  logic        start; // one unit to move
  logic [31:0] src;   // read address
  logic [31:0] dst;   // write address
  logic [1:0]  size;  // 0 byte, 1 half, 2 word
  logic        done;  // unit written
  modport eng  (output start, src, dst, size, input done);
  modport port (input start, src, dst, size, output done);
endinterface
`default_nettype wire

// file: design/dma_bus_port.sv
`default_nettype none
module dma_bus_port
  import dma_pkg::*;
(
  input  wire logic  pclk,    // system clock
  input  wire logic  presetn, // async reset, active low
  xfer_if.port       xf,      // unit request from engine
  output logic        m_req,  // bus request
  output logic        m_we,   // bus write
  output logic [31:0] m_addr, // bus address
  output logic [1:0]  m_size, // bus unit size
  output logic [31:0] m_wdata,// bus write data
  input  wire logic        m_ack,  // bus accept
  input  wire logic [31:0] m_rdata // bus read data
);
  port_state_e ps_reg;
  logic [31:0] dst_reg;
  logic [31:0] unit;
  logic        done_reg;

  // read data moved down from its read byte lane to lane 0
  assign unit    = m_rdata >> {m_addr[1:0], 3'h0};
  assign xf.done = done_reg;

  // one read then one write per unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_reg   <= PS_IDLE;
      m_req    <= 1'b0;
      m_we     <= 1'b0;
      m_addr   <= 32'h0;
      m_size   <= 2'h0;
      m_wdata  <= 32'h0;
      dst_reg  <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (ps_reg)
        PS_IDLE: if (xf.start) begin
          m_req   <= 1'b1;
          m_we    <= 1'b0;
          m_addr  <= xf.src;
          m_size  <= xf.size;
          dst_reg <= xf.dst;
          ps_reg  <= PS_RD;
        end
        PS_RD: if (m_ack) begin
          m_we    <= 1'b1;
          m_addr  <= dst_reg;
          m_wdata <= unit << {dst_reg[1:0], 3'h0};
          ps_reg  <= PS_WR;
        end
        PS_WR: if (m_ack) begin
          m_req    <= 1'b0;
          m_we     <= 1'b0;
          done_reg <= 1'b1;
          ps_reg   <= PS_IDLE;
        end
      endcase
    end
  end
endmodule // dma_bus_port
`default_nettype wire

// file: design/dma_ctrl.sv
`default_nettype none
module dma_ctrl
  import dma_pkg::*;
(
  input  wire logic           pclk,       // system clock
  input  wire logic           presetn,    // async reset, active low
  input  wire logic           psel,       // apb select
  input  wire logic           penable,    // apb access phase
  input  wire logic           pwrite,     // apb write
  input  wire logic [11:0]    paddr,      // apb byte address
  input  wire logic [31:0]    pwdata,     // apb write data
  output logic [31:0]         prdata,     // apb read data
  output logic                pready,     // apb ready
  output logic                pslverr,    // apb error
  input  wire logic [NCH-1:0] periph_req, // peripheral requests
  output logic                m_req,      // system bus request
  output logic                m_we,       // system bus write
  output logic [31:0]         m_addr,     // system bus address
  output logic [1:0]          m_size,     // system bus unit size
  output logic [31:0]         m_wdata,    // system bus write data
  input  wire logic           m_ack,      // system bus accept
  input  wire logic [31:0]    m_rdata,    // system bus read data
  output logic [NCH-1:0]      evt_link,   // event link pulses
  output logic                irq,        // combined interrupt
  output logic                shared_upper_channel_irq // ch 4..7
);
  // channel state
  logic [31:0]      sar_reg [NCH], dar_reg [NCH]; // live addresses
  logic [31:0]      sst_reg [NCH], dst_reg [NCH]; // start addresses
  logic [31:0]      mode_reg [NCH];
  logic [CNT_W-1:0] cnt_reg [NCH];
  logic [BLK_W-1:0] blk_reg [NCH];
  logic [BSZ_W-1:0] bsz_reg [NCH], rpt_reg [NCH];
  logic [NCH-1:0]   en_reg, pend_reg, prev_reg, evt_reg;
  logic [15:0]      stat_reg, ien_reg;
  logic             stop_reg, start_reg;
  eng_state_e       state_reg;
  logic [2:0]       ch_reg;
  logic [31:0]      prdata_reg;
  // bus decode
  logic             ch_sel, glb_ok, wr;
  logic [2:0]       a_ch, a_rg;
  logic [31:0]      rd_val;
  // arbitration and unit update
  logic [NCH-1:0]   ready_req;
  logic [2:0]       gch, c;
  xfer_mode_e       md;
  logic [1:0]       sz;
  logic [31:0]      step, s_nx, d_nx;
  logic             grant, free, s_wrap, d_wrap, rpt_last, more, done;
  logic             u_end, u_esc, u_evt, rld_s, rld_d;
  logic [3:0]       upmon;
  xfer_if xf ();
  dma_bus_port u_port (
    .pclk    (pclk),
    .presetn (presetn),
    .xf      (xf.port),
    .m_req   (m_req),
    .m_we    (m_we),
    .m_addr  (m_addr),
    .m_size  (m_size),
    .m_wdata (m_wdata),
    .m_ack   (m_ack),
    .m_rdata (m_rdata)
  );
  // first set bit from channel 0 upward
  function automatic logic [2:0] pick(input logic [NCH-1:0] r);
    pick = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (r[i]) begin
        pick = i[2:0];
      end
    end
  endfunction
  // step an address; inside a repeat area only low bits move
  function automatic logic [32:0] addr_step(input logic [31:0] a,
                                            input logic [31:0] st,
                                            input logic [4:0]  area);
    logic [4:0]  ar;
    logic [31:0] m;
    logic [31:0] lo;
    ar = (area > AREA_MAX) ? AREA_MAX : area;
    m  = (ar == 5'h0) ? 32'hFFFF_FFFF : ((32'h1 << ar) - 32'h1);
    lo = (a & m) + st;
    addr_step = {(ar != 5'h0) && ((lo & ~m) != 32'h0),
                 (a & ~m) | (lo & m)};
  endfunction
  // apb decode; zero wait states
  assign ch_sel  = (paddr[11:8] == 4'h0);
  assign a_ch    = paddr[7:5];
  assign a_rg    = paddr[4:2];
  assign glb_ok  = (paddr == A_IRQ_STAT) || (paddr == A_IRQ_CLR) ||
                   (paddr == A_IRQ_EN) || (paddr == A_UPMON) ||
                   (paddr == A_STOP);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(ch_sel | glb_ok);
  assign wr      = psel & penable & pwrite & (ch_sel | glb_ok);
  assign prdata  = prdata_reg;
  // interrupt and event outputs; each status bit needs its own enable
  assign upmon    = (stat_reg[7:4] & ien_reg[7:4]) |
                    (stat_reg[15:12] & ien_reg[15:12]);
  assign shared_upper_channel_irq = |upmon;
  assign irq      = |(stat_reg & ien_reg);
  assign evt_link = evt_reg;
  // engine side of the unit port
  assign xf.start = start_reg;
  assign xf.src   = sar_reg[ch_reg];
  assign xf.dst   = dar_reg[ch_reg];
  assign xf.size  = sz;
  assign done     = xf.done;

  // arbitration
  assign ready_req = en_reg & pend_reg;
  assign grant     = (state_reg == ST_IDLE) && !stop_reg &&
                     (|ready_req);
  assign gch       = pick(ready_req);
  // read data mux
  always_comb begin
    rd_val = 32'h0;
    if (ch_sel) begin
      unique case (a_rg)
        R_SRC:   rd_val = sar_reg[a_ch];
        R_DST:   rd_val = dar_reg[a_ch];
        R_CNT:   rd_val = {6'h0, bsz_reg[a_ch], cnt_reg[a_ch]};
        R_BLK:   rd_val = {16'h0, blk_reg[a_ch]};
        R_MODE:  rd_val = mode_reg[a_ch];
        R_CTRL:  rd_val = {31'h0, en_reg[a_ch]};
        R_SWREQ: rd_val = 32'h0;
        R_CHST:  rd_val = {6'h0, rpt_reg[a_ch], 13'h0,
                           (state_reg == ST_MOVE) && (ch_reg == a_ch),
                           pend_reg[a_ch], en_reg[a_ch]};
      endcase
    end else if (paddr == A_IRQ_STAT) begin
      rd_val = {16'h0, stat_reg};
    end else if (paddr == A_IRQ_EN) begin
      rd_val = {16'h0, ien_reg};
    end else if (paddr == A_UPMON) begin
      rd_val = {28'h0, upmon};
    end else if (paddr == A_STOP) begin
      rd_val = {31'h0, stop_reg};
    end
  end
  // read data caught in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_val;
    end
  end
  // outcome of the unit now finishing on the active channel
  always_comb begin
    c        = ch_reg;
    md       = xfer_mode_e'(mode_reg[c][MODE_LSB +: 2]);
    free     = mode_reg[c][FREE_BIT];
    sz       = (mode_reg[c][SIZE_LSB +: 2] == 2'h3) ? 2'h2 :
               mode_reg[c][SIZE_LSB +: 2];
    step     = 32'h1 << sz;
    {s_wrap, s_nx} = addr_step(sar_reg[c],
                               mode_reg[c][SINC_BIT] ? step : 32'h0,
                               mode_reg[c][SAREA_LSB +: 5]);
    {d_wrap, d_nx} = addr_step(dar_reg[c],
                               mode_reg[c][DINC_BIT] ? step : 32'h0,
                               mode_reg[c][DAREA_LSB +: 5]);
    rpt_last = (rpt_reg[c] == 10'h1);
    u_end    = 1'b0;
    u_evt    = 1'b0;
    rld_s    = 1'b0;
    rld_d    = 1'b0;
    more     = 1'b0;
    unique case (md)
      MODE_REPEAT: begin
        u_evt = 1'b1;
        u_end = (cnt_reg[c] == 16'h1) && !free;
        rld_s = rpt_last && !mode_reg[c][RSIDE_BIT];
        rld_d = rpt_last && mode_reg[c][RSIDE_BIT];
      end
      MODE_BLOCK: begin
        u_evt = rpt_last;
        u_end = rpt_last && (blk_reg[c] == 16'h1) && !free;
        more  = !rpt_last;
      end
      default: begin
        u_evt = 1'b1;
        u_end = (cnt_reg[c] == 16'h1) && !free;
      end
    endcase
    u_esc = (md == MODE_REPEAT && rpt_last) || s_wrap || d_wrap;
  end
  // engine sequencing: one unit, or a whole block, per grant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      ch_reg    <= 3'h0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: if (grant) begin
          ch_reg    <= gch;
          start_reg <= 1'b1;
          state_reg <= ST_MOVE;
        end
        ST_MOVE: if (done) begin
          if (more && en_reg[c]) begin
            start_reg <= 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end
  // source and destination addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        sar_reg[i] <= 32'h0;
        dar_reg[i] <= 32'h0;
        sst_reg[i] <= 32'h0;
        dst_reg[i] <= 32'h0;
      end
    end else begin
      if (done) begin
        sar_reg[c] <= rld_s ? sst_reg[c] : s_nx;
        dar_reg[c] <= rld_d ? dst_reg[c] : d_nx;
      end
      if (wr && ch_sel && a_rg == R_SRC) begin
        sar_reg[a_ch] <= pwdata;
        sst_reg[a_ch] <= pwdata;
      end
      if (wr && ch_sel && a_rg == R_DST) begin
        dar_reg[a_ch] <= pwdata;
        dst_reg[a_ch] <= pwdata;
      end
    end
  end
  // transfer, repeat and block counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_reg[i] <= 16'h0;
        blk_reg[i] <= 16'h0;
        bsz_reg[i] <= 10'h0;
        rpt_reg[i] <= 10'h0;
      end
    end else begin
      if (done) begin
        if (md != MODE_BLOCK) begin
          cnt_reg[c] <= cnt_reg[c] - 16'h1;
        end
        if (md != MODE_NORMAL) begin
          rpt_reg[c] <= rpt_last ? bsz_reg[c] : rpt_reg[c] - 10'h1;
        end
        if (md == MODE_BLOCK && rpt_last) begin
          blk_reg[c] <= blk_reg[c] - 16'h1;
        end
      end
      if (wr && ch_sel && a_rg == R_CNT) begin
        cnt_reg[a_ch] <= pwdata[CNT_W-1:0];
        bsz_reg[a_ch] <= pwdata[BSZ_LSB +: BSZ_W];
        rpt_reg[a_ch] <= pwdata[BSZ_LSB +: BSZ_W];
      end
      if (wr && ch_sel && a_rg == R_BLK) begin
        blk_reg[a_ch] <= pwdata[BLK_W-1:0];
      end
    end
  end
  // mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        mode_reg[i] <= MODE_RST;
      end
    end else if (wr && ch_sel && a_rg == R_MODE) begin
      mode_reg[a_ch] <= pwdata;
    end
  end
  // enables; a channel that ends drops its own enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= '0;
    end else begin
      if (done && u_end) begin
        en_reg[c] <= 1'b0;
      end
      if (wr && ch_sel && a_rg == R_CTRL) begin
        en_reg[a_ch] <= pwdata[0];
      end
    end
  end
  // start requests; a disabled channel keeps none, so enabling
  // it later cannot start a stale transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
      prev_reg <= '0;
    end else begin
      prev_reg <= periph_req;
      for (int i = 0; i < NCH; i++) begin
        if ((grant && gch == i[2:0]) || !en_reg[i]) begin
          pend_reg[i] <= 1'b0;
        end
        if (en_reg[i] &&
            ((wr && ch_sel && a_rg == R_SWREQ && a_ch == i[2:0] &&
              pwdata[0] && !mode_reg[i][TRIG_BIT]) ||
             (mode_reg[i][TRIG_BIT] && periph_req[i] && !prev_reg[i]))) begin
          pend_reg[i] <= 1'b1;
        end
      end
    end
  end
  // sticky status: end in low byte, escape in high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 16'h0;
    end else begin
      if (wr && paddr == A_IRQ_CLR) begin
        stat_reg <= stat_reg & ~pwdata[15:0];
      end
      if (done && u_end) begin
        stat_reg[c] <= 1'b1;
      end
      if (done && u_esc) begin
        stat_reg[{1'b1, c}] <= 1'b1;
      end
    end
  end
  // interrupt enable and module stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_reg  <= 16'h0;
      stop_reg <= STOP_RST;
    end else begin
      if (wr && paddr == A_IRQ_EN) begin
        ien_reg <= pwdata[15:0];
      end
      if (wr && paddr == A_STOP) begin
        stop_reg <= pwdata[0];
      end
    end
  end
  // event link pulse per unit, or per block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= '0;
    end else begin
      evt_reg <= '0;
      if (done && u_evt) begin
        evt_reg[c] <= 1'b1;
      end
    end
  end
endmodule // dma_ctrl
`default_nettype wire

// file: bench/dma_ctrl_properties.sv
`default_nettype none
module dma_ctrl_properties
  import dma_pkg::*;
(
  input wire logic           pclk,     // clock
  input wire logic           presetn,  // reset, active low
  input wire logic           psel,     // apb select
  input wire logic           penable,  // apb access
  input wire logic [11:0]    paddr,    // apb address
  input wire logic           pready,   // apb ready
  input wire logic           pslverr,  // apb error
  input wire logic           m_req,    // bus request
  input wire logic           m_we,     // bus write
  input wire logic [31:0]    m_addr,   // bus address
  input wire logic [1:0]     m_size,   // bus unit size
  input wire logic           m_ack,    // bus accept
  input wire logic [NCH-1:0] evt_link, // event pulses
  input wire logic           irq,      // interrupt
  input wire logic           shared_upper_channel_irq // upper irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ack;
  // write half of a unit accepted
  assign wr_ack = m_req && m_ack && m_we;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr >= 12'h114
    |-> pslverr) else $error("no error on unmapped");
  a_err_mapped: assert property (psel && penable && paddr < 12'h100
    |-> !pslverr) else $error("error on channel window");
  a_unit_size: assert property (m_req |-> m_size != 2'h3)
    else $error("illegal unit size");
  a_req_held: assert property (m_req && !m_ack |=> m_req &&
    $stable(m_addr) && $stable(m_we) && $stable(m_size))
    else $error("request changed before accept");
  a_read_write: assert property (m_req && m_ack && !m_we
    |=> m_req && m_we) else $error("read not followed by write");
  a_write_ends: assert property (wr_ack |=> !m_req)
    else $error("request kept after write");
  a_evt_pulse: assert property (|evt_link
    |=> (evt_link & $past(evt_link)) == '0) else $error("event too long");
  a_evt_single: assert property ($onehot0(evt_link))
    else $error("two channels served at once");
  a_evt_cause: assert property ($rose(|evt_link)
    |-> $past(wr_ack, 1) || $past(wr_ack, 2))
    else $error("event without write");
  a_upper_irq: assert property (shared_upper_channel_irq |-> irq)
    else $error("upper irq without irq");
endmodule // dma_ctrl_properties
bind dma_ctrl dma_ctrl_properties chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .m_req(m_req), .m_we(m_we), .m_addr(m_addr),
  .m_size(m_size), .m_ack(m_ack), .evt_link(evt_link), .irq(irq),
  .shared_upper_channel_irq(shared_upper_channel_irq));
`default_nettype wire

// file: bench/dma_bus_slave.sv
`default_nettype none
module dma_bus_slave (
  input  wire logic        pclk,    // clock
  input  wire logic        presetn, // reset, active low
  input  wire logic        m_req,   // request
  input  wire logic        m_we,    // write
  input  wire logic [31:0] m_addr,  // address
  input  wire logic [1:0]  m_size,  // unit size
  input  wire logic [31:0] m_wdata, // write data
  input  wire logic [3:0]  lat,     // wait cycles before accept
  output logic             m_ack,   // accept
  output logic [31:0]      m_rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  logic [3:0]  wcnt;
  logic [31:0] bmask;
  // lanes touched by the unit at this address
  always_comb begin
    case (m_size)
      2'h0: bmask = 32'h0000_00FF << {m_addr[1:0], 3'b000};
      2'h1: bmask = 32'h0000_FFFF << {m_addr[1:0], 3'b000};
      default: bmask = 32'hFFFF_FFFF;
    endcase
  end
  // accept after lat cycles; read lines toggle while unused
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ack   <= 1'b0;
      m_rdata <= 32'h0;
      wcnt    <= 4'h0;
    end else begin
      m_ack   <= 1'b0;
      m_rdata <= ~m_rdata;
      if (m_req && m_ack && m_we)
        mem[m_addr[9:2]] <= (mem[m_addr[9:2]] & ~bmask) | (m_wdata & bmask);
      if (m_req && !m_ack) begin
        if (wcnt >= lat) begin
          m_ack <= 1'b1;
          wcnt  <= 4'h0;
          if (!m_we)
            m_rdata <= mem[m_addr[9:2]];
        end else
          wcnt <= wcnt + 4'h1;
      end
    end
  end
endmodule // dma_bus_slave
`default_nettype wire

// file: bench/multichannel_dma_controller_tb.sv
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module multichannel_dma_controller_tb
  import dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]    paddr = '0;
  logic [31:0]    pwdata = '0, prdata, m_addr, m_wdata, m_rdata, rd;
  logic [NCH-1:0] periph_req = '0, evt_link, first_evt;
  logic [3:0]     lat = '0;
  logic [1:0]     m_size;
  logic           pready, pslverr, m_req, m_we, m_ack, irq, upirq, err;
  int             n_errors = 0, cmp_count = 0, evt_total = 0;
  logic [31:0]    xs [3] = '{32'h55, 32'h6655, 32'h8877_6655};
  dma_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .m_req(m_req), .m_we(m_we), .m_addr(m_addr),
    .m_size(m_size), .m_wdata(m_wdata), .m_ack(m_ack), .m_rdata(m_rdata),
    .evt_link(evt_link), .irq(irq), .shared_upper_channel_irq(upirq));
  dma_bus_slave slv (.pclk(pclk), .presetn(presetn), .m_req(m_req),
    .m_we(m_we), .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata),
    .lat(lat), .m_ack(m_ack), .m_rdata(m_rdata));
  always #10 pclk = ~pclk;
  // count event pulses and keep the first
  always @(posedge pclk) begin
    if (|evt_link) begin
      if (evt_total == 0)
        first_evt = evt_link;
      evt_total++;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] ra(input int ch, input logic [2:0] r);
    return 12'(ch * 32) + {7'h00, r, 2'b00};
  endfunction
  function automatic logic [31:0] mw(input logic [1:0] md,
                                     input logic [1:0] sz);
    return {30'h0, md} | ({30'h0, sz} << SIZE_LSB) | (32'h1 << SINC_BIT)
      | (32'h1 << DINC_BIT);
  endfunction
  task automatic cfg(input int ch, input logic [31:0] s, d, c, b, md);
    apb(1'b1, ra(ch, R_SRC), s);
    apb(1'b1, ra(ch, R_DST), d);
    apb(1'b1, ra(ch, R_CNT), c);
    apb(1'b1, ra(ch, R_BLK), b);
    apb(1'b1, ra(ch, R_MODE), md);
    apb(1'b1, ra(ch, R_CTRL), 32'h1);
  endtask
  task automatic go(input int ch);
    apb(1'b1, ra(ch, R_SWREQ), 32'h1);
  endtask
  task automatic clr_all;
    apb(1'b1, A_IRQ_CLR, 32'hFFFF);
    evt_total = 0;
  endtask
  task automatic wait_stat(input logic [31:0] m);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, A_IRQ_STAT, 32'h0);
      if ((rd & m) == m)
        break;
    end
    `CHK(rd & m, m)
  endtask
  task automatic wait_evt(input int n);
    for (int i = 0; i < 200 && evt_total < n; i++)
      @(posedge pclk);
    `CHK(evt_total, n)
  endtask
  task automatic chk_irq(input logic e);
    @(posedge pclk);
    `CHK(irq, e)
  endtask
  task automatic t_regs;
    apb(1'b0, ra(0, R_MODE), 32'h0);
    `CHK(rd, MODE_RST)
    apb(1'b0, A_STOP, 32'h0);
    `CHK(rd[0], STOP_RST)
    apb(1'b1, ra(5, R_BLK), 32'h0000_FFFF);
    apb(1'b0, ra(5, R_BLK), 32'h0);
    `CHK(rd[15:0], 16'hFFFF)
    apb(1'b0, 12'h200, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test regs done");
  endtask
  task automatic t_sizes;
    slv.mem[8'h10] = 32'h8877_6655;
    for (int sz = 0; sz < 3; sz++) begin
      slv.mem[8'h20] = 32'h0;
      lat = 4'(sz);
      clr_all();
      cfg(0, 32'h40, 32'h80, 32'h1, 32'h1, mw(MODE_NORMAL, 2'(sz)));
      go(0);
      wait_stat(32'h1);
      `CHK(slv.mem[8'h20], xs[sz])
      `CHK(evt_total, 1)
    end
    apb(1'b1, A_IRQ_EN, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, A_IRQ_EN, 32'h1);
    chk_irq(1'b1);
    clr_all();
    chk_irq(1'b0);
    go(0);
    repeat (40) @(posedge pclk);
    `CHK(evt_total, 0)
    apb(1'b1, A_IRQ_EN, 32'h0);
    $display("test sizes done");
  endtask
  task automatic t_prio;
    lat = 4'h1;
    cfg(0, 32'h40, 32'h84, 32'h1, 32'h1, mw(MODE_NORMAL, 2'h2)
      | (32'h1 << TRIG_BIT));
    cfg(1, 32'h40, 32'h88, 32'h1, 32'h1, mw(MODE_NORMAL, 2'h2)
      | (32'h1 << TRIG_BIT));
    clr_all();
    @(posedge pclk);
    periph_req <= 8'h03;
    wait_stat(32'h3);
    `CHK(first_evt, 8'h01)
    periph_req <= 8'h00;
    $display("test priority done");
  endtask
  task automatic t_repeat;
    slv.mem[8'h30] = 32'hA1A1_0001;
    slv.mem[8'h31] = 32'hB2B2_0002;
    slv.mem[8'h32] = 32'hC3C3_0003;
    clr_all();
    cfg(2, 32'hC0, 32'h100, 32'h0002_0004, 32'h1, mw(MODE_REPEAT, 2'h2));
    for (int k = 1; k <= 4; k++) begin
      go(2);
      wait_evt(k);
    end
    wait_stat(32'h404);
    for (int k = 0; k < 4; k++)
      `CHK(slv.mem[8'h40 + k], slv.mem[8'h30 + k % 2])
    $display("test repeat done");
  endtask
  task automatic t_block;
    lat = 4'h2;
    clr_all();
    cfg(5, 32'hC0, 32'h140, 32'h0003_0003, 32'h1, mw(MODE_BLOCK, 2'h2));
    go(5);
    wait_stat(32'h20);
    `CHK(evt_total, 1)
    `CHK(slv.mem[8'h52], 32'hC3C3_0003)
    `CHK(slv.mem[8'h50], 32'hA1A1_0001)
    apb(1'b1, A_IRQ_EN, 32'h2000);
    apb(1'b0, A_UPMON, 32'h0);
    `CHK({upirq, rd[3:0]}, 5'h00)
    apb(1'b1, A_IRQ_EN, 32'h0020);
    apb(1'b0, A_UPMON, 32'h0);
    `CHK({upirq, rd[3:0]}, 5'h12)
    apb(1'b1, A_IRQ_EN, 32'h0);
    $display("test block done");
  endtask
  task automatic t_area;
    slv.mem[8'h62] = 32'h0;
    lat = 4'h0;
    clr_all();
    cfg(0, 32'hC0, 32'h180, 32'h3, 32'h1, mw(MODE_NORMAL, 2'h2)
      | (32'h3 << DAREA_LSB));
    apb(1'b1, A_STOP, 32'h1);
    go(0);
    repeat (30) @(posedge pclk);
    `CHK(evt_total, 0)
    apb(1'b1, A_STOP, 32'h0);
    wait_evt(1);
    for (int k = 2; k <= 3; k++) begin
      go(0);
      wait_evt(k);
    end
    wait_stat(32'h101);
    `CHK(slv.mem[8'h60], 32'hC3C3_0003)
    `CHK(slv.mem[8'h61], 32'hB2B2_0002)
    `CHK(slv.mem[8'h62], 32'h0)
    $display("test area done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sizes();
    t_prio();
    t_repeat();
    t_block();
    t_area();
    wrap_up();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
endmodule // multichannel_dma_controller_tb
`default_nettype wire
